/* File: ubt_pkg.sv */
// shared constants and types for the uart baud, framing and transmit block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package ubt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_TXD = 8'h08;
  localparam logic [7:0] OFS_ERR = 8'h0c;
  localparam logic [7:0] OFS_RXD = 8'h10;
  localparam logic [7:0] OFS_FLAG = 8'h14;
  // values after reset
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [6:0] RST_BAUD = 7'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_ERR = 3'h0;
  // field positions
  localparam int MODE_TXE = 7;
  localparam int MODE_RXE = 6;
  localparam int MODE_PAR = 4;
  localparam int MODE_CL = 3;
  localparam int MODE_SL = 2;
  localparam int BAUD_TPS = 4;
  localparam int BAUD_MDL = 0;
  localparam int ERR_PE = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_OVE = 0;
  localparam int FLAG_DONE = 0;
  localparam int FLAG_BUSY = 1;
  // counts: divisor base 16 gives a terminal count of 15 plus k
  localparam logic [4:0] DIV_BASE_LAST = 5'h0f;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  // parity select codes
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD = 2'h2,
    PAR_EVEN = 2'h3
  } ubt_par_e;
  // frame position, shared by transmitter and receiver
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PAR = 5'h08,
    ST_STOP = 5'h10
  } ubt_frm_e;
endpackage : ubt_pkg

/* File: ubt_cfg_if.sv */
// configuration carried from the register file to the baud and receive logic
`timescale 1ns/10ps
interface ubt_cfg_if;
  import ubt_pkg::*;
  logic [2:0] prescale_sel;
  logic [3:0] divisor_sel;
  ubt_par_e parity_mode;
  logic char8;
  modport src (output prescale_sel, output divisor_sel, output parity_mode, output char8);
  modport dst (input prescale_sel, input divisor_sel, input parity_mode, input char8);
endinterface : ubt_cfg_if

/* File: ubt_baud_gen.sv */
// baud generator: prescaler plus 5-bit counter, gives a tick every half bit
`timescale 1ns/10ps
module ubt_baud_gen
  import ubt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  ubt_cfg_if.dst cfg,
  output logic half_tick
);
  logic [7:0] pre_ff;
  logic [4:0] cnt_ff;
  logic [8:0] pre_last;
  logic [4:0] cnt_last;
  logic fsck_tick;

  // ----------------------------------------------------------------------
  // terminal counts
  // ----------------------------------------------------------------------
  // fsck period is 2^(n+1) pclk cycles, counter wraps after 16+k fsck
  assign pre_last = (9'h002 << cfg.prescale_sel) - 9'h001;
  assign cnt_last = DIV_BASE_LAST + {1'b0, cfg.divisor_sel};
  assign fsck_tick = (pre_ff == pre_last[7:0]);
  // two half ticks make one bit: 2^(n+2)*(16+k) pclk cycles
  assign half_tick = fsck_tick & (cnt_ff == cnt_last);

  // ----------------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------------
  // restart aligns the bit grid to a frame edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 8'h00;
      cnt_ff <= 5'h00;
    end else if (restart) begin
      pre_ff <= 8'h00;
      cnt_ff <= 5'h00;
    end else begin
      pre_ff <= fsck_tick ? 8'h00 : pre_ff + 8'h01;
      if (fsck_tick) begin
        cnt_ff <= (cnt_ff == cnt_last) ? 5'h00 : cnt_ff + 5'h01;
      end
    end
  end
endmodule : ubt_baud_gen

/* File: ubt_rx.sv */
// receiver: samples the serial input, checks parity and stop, keeps errors
`timescale 1ns/10ps
module ubt_rx
  import ubt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  ubt_cfg_if.dst cfg,
  input wire logic rx_en,
  input wire logic rx_pin,
  input wire logic rd_ack,
  output logic [7:0] rx_data,
  output logic [2:0] rx_err,
  output logic rx_full
);
  logic s1_ff, s2_ff, s3_ff, line_ff;
  ubt_frm_e st_ff;
  logic half_ff, acc_ff;
  logic [2:0] bit_ff;
  logic [7:0] sh_ff;
  logic half_tick, restart, samp, last, pe, done;
  logic [7:0] word;

  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  // line level moves only when the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      line_ff <= 1'b1;
    end else begin
      s1_ff <= rx_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) line_ff <= s3_ff;
    end
  end

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  assign restart = (st_ff == ST_IDLE) & rx_en & ~line_ff;
  assign samp = half_tick & half_ff;
  assign last = bit_ff == (cfg.char8 ? LAST_BIT_8 : LAST_BIT_7);
  // 7-bit data sits high in the shifter; bit 7 returns zero
  assign word = cfg.char8 ? sh_ff : {1'b0, sh_ff[7:1]};
  // zero and none modes never report a parity error
  assign pe = (cfg.parity_mode == PAR_EVEN) ? acc_ff :
              (cfg.parity_mode == PAR_ODD) ? ~acc_ff : 1'b0;
  // only the first stop bit is checked
  assign done = (st_ff == ST_STOP) & samp;

  ubt_baud_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .cfg(cfg),
    .half_tick(half_tick)
  );

  // ----------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------
  // first tick after restart lands mid start bit, then every second one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      half_ff <= 1'b0;
      acc_ff <= 1'b0;
      bit_ff <= 3'h0;
      sh_ff <= RST_BYTE;
    end else if (!rx_en) begin
      st_ff <= ST_IDLE;
    end else begin
      if (half_tick) half_ff <= ~half_ff;
      unique case (st_ff)
        ST_IDLE: begin
          half_ff <= 1'b1;
          acc_ff <= 1'b0;
          bit_ff <= 3'h0;
          if (restart) st_ff <= ST_START;
        end
        ST_START: if (samp) st_ff <= line_ff ? ST_IDLE : ST_DATA;
        ST_DATA: if (samp) begin
          sh_ff <= {line_ff, sh_ff[7:1]};
          acc_ff <= acc_ff ^ line_ff;
          bit_ff <= bit_ff + 3'h1;
          if (last) st_ff <= (cfg.parity_mode == PAR_NONE) ? ST_STOP : ST_PAR;
        end
        ST_PAR: if (samp) begin
          acc_ff <= acc_ff ^ line_ff;
          st_ff <= ST_STOP;
        end
        ST_STOP: if (samp) st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // buffer and error status
  // ----------------------------------------------------------------------
  // a new frame replaces all flags; completion wins over a same-cycle read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= RST_BYTE;
      rx_err <= RST_ERR;
      rx_full <= 1'b0;
    end else if (done) begin
      rx_data <= word;
      rx_err <= {pe, ~line_ff, rx_full & ~rd_ack};
      rx_full <= 1'b1;
    end else if (rd_ack) begin
      rx_err <= RST_ERR;
      rx_full <= 1'b0;
    end
  end
endmodule : ubt_rx

/* File: ubt_uart_top.sv */
// uart top: apb register file, transmitter and serial line drivers
`timescale 1ns/10ps
module ubt_uart_top
  import ubt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx_line,
  output logic serial_tx_line,
  output logic transmit_done_irq
);
  // ----------------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------------
  logic [7:1] serial_mode_register_ff;
  logic [6:0] baud_divider_control_ff;
  logic transmit_done_irq_flag_ff;
  ubt_frm_e tx_st_ff, nxt_tx_st;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic [2:0] tx_bit_ff, nxt_tx_bit;
  logic tx_par_ff, nxt_tx_par;
  logic tx_phase_ff, nxt_tx_phase;
  logic tx_stop2_ff, nxt_tx_stop2;
  logic nxt_tx_line;
  logic tx_end;
  logic [7:0] rx_data;
  logic [2:0] rx_err;
  logic rx_full;
  logic tx_tick;

  ubt_cfg_if cfg ();

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic acc, setup_acc, fire, wr_fire, rd_fire;
  logic sel_mode, sel_baud, sel_txd, sel_err, sel_rxd, sel_flag, mapped;
  logic [31:0] rd_mux;
  assign acc = psel & penable;
  // access phase takes two cycles: pready is raised from a flop
  assign setup_acc = acc & ~pready;
  assign fire = acc & pready;
  assign wr_fire = fire & pwrite;
  assign rd_fire = fire & ~pwrite;
  assign sel_mode = paddr == OFS_MODE;
  assign sel_baud = paddr == OFS_BAUD;
  assign sel_txd = paddr == OFS_TXD;
  assign sel_err = paddr == OFS_ERR;
  assign sel_rxd = paddr == OFS_RXD;
  assign sel_flag = paddr == OFS_FLAG;
  assign mapped = sel_mode | sel_baud | sel_txd | sel_err | sel_rxd | sel_flag;

  // read selection; reserved bits read zero, shift register reads zero
  assign rd_mux = sel_mode ? {24'h000000, serial_mode_register_ff, 1'b0} :
                  sel_baud ? {25'h0000000, baud_divider_control_ff} :
                  sel_err ? {29'h00000000, rx_err} :
                  sel_rxd ? {24'h000000, rx_data} :
                  sel_flag ? {30'h00000000, tx_st_ff != ST_IDLE,
                              transmit_done_irq_flag_ff} :
                  32'h00000000;

  // ----------------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------------
  logic tx_en, rx_en, stop2;
  assign tx_en = serial_mode_register_ff[MODE_TXE];
  assign rx_en = serial_mode_register_ff[MODE_RXE];
  assign stop2 = serial_mode_register_ff[MODE_SL];
  assign cfg.parity_mode = ubt_par_e'(serial_mode_register_ff[MODE_PAR +: 2]);
  assign cfg.char8 = serial_mode_register_ff[MODE_CL];
  assign cfg.prescale_sel = baud_divider_control_ff[BAUD_TPS +: 3];
  assign cfg.divisor_sel = baud_divider_control_ff[BAUD_MDL +: 4];

  // ----------------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------------
  // read data and error are caught when pready rises and hold to the fire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_acc;
      if (setup_acc) prdata <= pwrite ? 32'h00000000 : rd_mux;
      if (setup_acc) pslverr <= ~mapped;
    end
  end

  // ----------------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------------
  // software must keep these still while a frame is on the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_register_ff <= RST_MODE[7:1];
      baud_divider_control_ff <= RST_BAUD;
    end else begin
      if (wr_fire & sel_mode) serial_mode_register_ff <= pwdata[7:1];
      if (wr_fire & sel_baud) baud_divider_control_ff <= pwdata[6:0];
    end
  end

  // ----------------------------------------------------------------------
  // transmit completion flag
  // ----------------------------------------------------------------------
  // write one to clear; a completion in the same cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_done_irq_flag_ff <= 1'b0;
      transmit_done_irq <= 1'b0;
    end else begin
      transmit_done_irq <= tx_end;
      if (tx_end) begin
        transmit_done_irq_flag_ff <= 1'b1;
      end else if (wr_fire & sel_flag & pwdata[FLAG_DONE]) begin
        transmit_done_irq_flag_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------------
  logic tx_load, bit_end, tx_last;
  logic [7:0] tx_word;
  logic tx_par_bit;
  // a byte is taken only with transmit enabled and the shifter idle
  assign tx_load = wr_fire & sel_txd & tx_en & (tx_st_ff == ST_IDLE);
  // 7-bit mode masks bit 7 before it can reach parity or the line
  assign tx_word = cfg.char8 ? pwdata[7:0] : {1'b0, pwdata[6:0]};
  assign tx_par_bit = (cfg.parity_mode == PAR_EVEN) ? ^tx_word :
                      (cfg.parity_mode == PAR_ODD) ? ~^tx_word : 1'b0;
  // two half ticks per bit, counted from the load edge
  assign bit_end = tx_tick & tx_phase_ff;
  assign tx_last = tx_bit_ff == (cfg.char8 ? LAST_BIT_8 : LAST_BIT_7);
  assign tx_end = (tx_st_ff == ST_STOP) & bit_end & (tx_stop2_ff | ~stop2);

  ubt_baud_gen u_tx_baud (
    .pclk(pclk),
    .presetn(presetn),
    .restart(tx_load),
    .cfg(cfg),
    .half_tick(tx_tick)
  );

  // next-state logic of the frame sequencer
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tx_stop2 = tx_stop2_ff;
    nxt_tx_phase = tx_tick ? ~tx_phase_ff : tx_phase_ff;
    nxt_tx_line = serial_tx_line;
    unique case (tx_st_ff)
      ST_IDLE: begin
        nxt_tx_line = 1'b1;
        if (tx_load) begin
          nxt_tx_st = ST_START;
          nxt_tx_sh = tx_word;
          nxt_tx_par = tx_par_bit;
          nxt_tx_bit = 3'h0;
          nxt_tx_phase = 1'b0;
          nxt_tx_stop2 = 1'b0;
          nxt_tx_line = 1'b0;
        end
      end
      ST_START: if (bit_end) begin
        nxt_tx_st = ST_DATA;
        nxt_tx_line = tx_sh_ff[0];
        nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
      end
      ST_DATA: if (bit_end) begin
        nxt_tx_bit = tx_bit_ff + 3'h1;
        nxt_tx_line = tx_sh_ff[0];
        nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
        if (tx_last) begin
          // no parity: straight to the stop bit
          nxt_tx_st = (cfg.parity_mode == PAR_NONE) ? ST_STOP : ST_PAR;
          nxt_tx_line = (cfg.parity_mode == PAR_NONE) ? 1'b1 : tx_par_ff;
        end
      end
      ST_PAR: if (bit_end) begin
        nxt_tx_st = ST_STOP;
        nxt_tx_line = 1'b1;
      end
      ST_STOP: if (bit_end) begin
        nxt_tx_line = 1'b1;
        nxt_tx_stop2 = 1'b1;
        if (tx_end) nxt_tx_st = ST_IDLE;
      end
      default: begin
        nxt_tx_st = ST_IDLE;
        nxt_tx_line = 1'b1;
      end
    endcase
  end

  // transmitter state; the line itself is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff <= ST_IDLE;
      tx_sh_ff <= RST_BYTE;
      tx_bit_ff <= 3'h0;
      tx_par_ff <= 1'b0;
      tx_phase_ff <= 1'b0;
      tx_stop2_ff <= 1'b0;
      serial_tx_line <= 1'b1;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_bit_ff <= nxt_tx_bit;
      tx_par_ff <= nxt_tx_par;
      tx_phase_ff <= nxt_tx_phase;
      tx_stop2_ff <= nxt_tx_stop2;
      serial_tx_line <= nxt_tx_line;
    end
  end

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  // reading the receive buffer clears it and the error status
  ubt_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg),
    .rx_en(rx_en),
    .rx_pin(serial_rx_line),
    .rd_ack(rd_fire & sel_rxd),
    .rx_data(rx_data),
    .rx_err(rx_err),
    .rx_full(rx_full)
  );
endmodule : ubt_uart_top

/* File: ubt_chk_monitor.sv */
// port-level assertion checker for the uart top
`timescale 1ns/10ps
module ubt_chk
  import ubt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_tx_line,
  input wire logic transmit_done_irq
);
  // ----------------------------------------
  // shadow of enable and busy
  // ----------------------------------------
  logic txe_ff;
  logic busy_ff;
  logic nxt_txe;
  logic nxt_busy;
  wire fire = psel && penable && pready && pwrite;
  wire tx_go = fire && paddr == OFS_TXD && txe_ff && !busy_ff;
  wire mapped = paddr inside {OFS_MODE, OFS_BAUD, OFS_TXD, OFS_ERR, OFS_RXD, OFS_FLAG};
  // busy mirrors the design: a write while busy is ignored, not queued
  assign nxt_txe = (fire && paddr == OFS_MODE) ? pwdata[MODE_TXE] : txe_ff;
  assign nxt_busy = tx_go | (busy_ff & ~transmit_done_irq);
  // shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txe_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      txe_ff <= nxt_txe;
      busy_ff <= nxt_busy;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // two-cycle access phase
  sequence s_access;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence
  apb_answer_a: assert property (psel && !penable |=> s_access)
    else $error("apb access phase not two cycles");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_map_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata nonzero on write");
  read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits nonzero");
  tx_start_a: assert property (tx_go |=> (!serial_tx_line) [*8])
    else $error("start bit missing after data write");
  idle_high_a: assert property (!busy_ff |-> serial_tx_line)
    else $error("line not high while idle");
  irq_pulse_a: assert property (transmit_done_irq |=> !transmit_done_irq)
    else $error("done request longer than one cycle");
  irq_busy_a: assert property (transmit_done_irq |-> busy_ff && serial_tx_line)
    else $error("done request outside a frame");
endmodule : ubt_chk

bind ubt_uart_top ubt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_tx_line(serial_tx_line),
  .transmit_done_irq(transmit_done_irq));

/* File: ubt_far.sv */
// far-end serial partner: samples the transmit line, drives the receive line
`timescale 1ns/10ps
module ubt_far (
  input wire logic clk,
  input wire logic [15:0] bitc,
  input wire logic tx,
  output logic rx,
  output logic [10:0] cap,
  output logic got
);
  // ----------------------------------------
  // line model
  // ----------------------------------------
  initial begin
    rx = 1'b1;
    cap = 11'h0;
    got = 1'b0;
  end
  // samples at mid-bit; eleven bits cover the longest frame after start
  always begin
    @(negedge tx);
    got = 1'b0;
    repeat (bitc / 2) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      repeat (bitc) @(posedge clk);
      cap[i] = tx;
    end
    got = 1'b1;
  end
  // one frame, lsb first; last bits high so the line rests idle
  task automatic send(input logic [11:0] bits);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      rx <= bits[i];
      repeat (bitc - 1) @(posedge clk);
    end
  endtask : send
endmodule : ubt_far

/* File: tb.sv */
// self-checking bench for the uart baud, framing and transmit block
`timescale 1ns/10ps
module tb;
  import ubt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxl, txl, irq, er, got;
  logic [31:0] rd;
  logic [10:0] cap;
  logic [15:0] bitc = 16'd64;
  int num_errors = 0;
  int checks = 0;
  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  always #5 pclk = ~pclk;
  ubt_uart_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_line(rxl), .serial_tx_line(txl), .transmit_done_irq(irq));
  ubt_far far (.clk(pclk), .bitc(bitc), .tx(txl), .rx(rxl), .cap(cap), .got(got));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer, then an idle cycle so strobes never toggle twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle budget here: only the watchdog may end a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_got();
    while (got !== 1'b1) begin
      @(posedge pclk);
    end
  endtask : wait_got
  function automatic logic [10:0] frame(input logic [7:0] d, input logic [1:0] p,
                                        input logic c);
    logic [10:0] f;
    logic [7:0] m;
    m = c ? d : {1'b0, d[6:0]};
    f = {3'h7, m};
    if (!c) f[7] = 1'b1;
    if (p != 2'h0) f[c ? 8 : 7] = (p == 2'h3) ? ^m : (p == 2'h2) ? ~^m : 1'b0;
    return f;
  endfunction : frame
  task automatic t_reset();
    logic [7:0] a [4] = '{OFS_MODE, OFS_BAUD, OFS_ERR, OFS_FLAG};
    foreach (a[j]) begin
      apb(1'b0, a[j], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(er, 32'h1);
    apb(1'b1, OFS_BAUD, 32'h7e);
    apb(1'b0, OFS_BAUD, 32'h0);
    chk(rd, 32'h7e);
    apb(1'b1, OFS_BAUD, 32'h0);
    apb(1'b1, OFS_TXD, 32'h5a);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  // start bit width for two divider settings
  task automatic t_baud();
    logic [7:0] b [2] = '{8'h13, 8'h2e};
    logic [15:0] w [2] = '{16'd152, 16'd480};
    int m;
    foreach (b[j]) begin
      apb(1'b1, OFS_BAUD, {24'h0, b[j]});
      bitc = w[j];
      apb(1'b1, OFS_MODE, 32'h88);
      apb(1'b1, OFS_TXD, 32'h01);
      m = 0;
      while (txl === 1'b0 && m < 5000) begin
        @(posedge pclk);
        m++;
      end
      chk(m, w[j]);
      wait_got();
      chk(cap, 11'h701);
    end
    apb(1'b1, OFS_BAUD, 32'h0);
    bitc = 16'd64;
  endtask : t_baud
  // every parity code, both lengths, both stop counts
  task automatic t_frames();
    logic [7:0] d;
    logic [1:0] p;
    int n;
    for (int i = 0; i < 8; i++) begin
      p = i[2:1];
      d = 8'hd3 + 8'(i);
      apb(1'b1, OFS_MODE, {24'h0, 2'b11, p, i[0], p[0], 2'b00});
      apb(1'b1, OFS_TXD, {24'h0, d});
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      chk((n + 32) / 64, 2 + (i[0] ? 8 : 7) + (p != 2'h0) + p[0]);
      wait_got();
      chk(cap, frame(d, p, i[0]));
      apb(1'b0, OFS_FLAG, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, OFS_FLAG, 32'h1);
      apb(1'b0, OFS_FLAG, 32'h0);
      chk(rd, 32'h0);
    end
  endtask : t_frames
  // bad even parity, low stop in 7-bit odd, bad odd parity, zero parity unchecked,
  // then two unread frames for an overrun
  task automatic t_rx();
    logic [7:0] m [4] = '{8'hf8, 8'he0, 8'hec, 8'hd8};
    logic [11:0] f [4] = '{{3'h7, 8'h35, 1'b0}, {2'h3, 1'b0, 1'b1, 7'h55, 1'b0},
                           {2'h3, 1'b0, 8'h0f, 1'b0}, {2'h3, 1'b1, 8'h01, 1'b0}};
    logic [2:0] e [4] = '{3'h4, 3'h2, 3'h4, 3'h0};
    logic [7:0] v [4] = '{8'h35, 8'h55, 8'h0f, 8'h01};
    foreach (m[j]) begin
      apb(1'b1, OFS_MODE, {24'h0, m[j]});
      far.send(f[j]);
      apb(1'b0, OFS_ERR, 32'h0);
      chk(rd, e[j]);
      apb(1'b0, OFS_RXD, 32'h0);
      chk(rd, v[j]);
      apb(1'b0, OFS_ERR, 32'h0);
      chk(rd, 32'h0);
    end
    far.send(f[3]);
    far.send(f[3]);
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, OFS_RXD, 32'h0);
    chk(rd, 32'h01);
  endtask : t_rx
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_baud();
    t_frames();
    t_rx();
    tally_and_finish();
  end
  // watchdog well past the expected run of about 20000 cycles
  initial begin
    repeat (50000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
endmodule : tb
